// >>> shared/rot_pkg.sv
package rot_pkg;
	// operation select codes from the instruction decoder
	localparam logic [2:0] op_none = 3'h0;
	localparam logic [2:0] op_rotate_left_copy = 3'h1;
	localparam logic [2:0] op_rotate_left_via_cy = 3'h2;
	localparam logic [2:0] op_rotate_left_via_cy_copy = 3'h3;
	localparam logic [2:0] op_rotate_right_in_place = 3'h4;
	localparam logic [2:0] op_rotate_right_copy = 3'h5;
	localparam logic [2:0] op_rotate_right_via_cy = 3'h6;
	// byte layout
	localparam int data_w = 8;
	localparam int msb_pos = 7;
	localparam int lsb_pos = 0;
	// reset values of the result registers
	localparam logic [7:0] acc_rst = 8'h00;
	localparam logic [7:0] mem_rst = 8'h00;
	localparam logic cy_rst = 1'b0;
endpackage

// >>> core/rot_shifter.sv
// combinational one-bit rotator; fill bit picked by the caller
module rot_shifter (
	input wire logic [7:0] din,
	input wire logic dir_right,
	input wire logic fill,
	output logic [7:0] dout,
	output logic out_bit
);
	always_comb begin
		if (dir_right) begin
			// bit 0 falls out, fill enters at the top
			dout = {fill, din[rot_pkg::msb_pos:1]};
			out_bit = din[rot_pkg::lsb_pos];
		end else begin
			// bit 7 falls out, fill enters at the bottom
			dout = {din[rot_pkg::msb_pos-1:0], fill};
			out_bit = din[rot_pkg::msb_pos];
		end
	end
endmodule

// >>> core/byte_rotate_unit.sv
module byte_rotate_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce, // freezes all state while low
	input wire logic op_valid, // one-cycle instruction strobe
	input wire logic [2:0] op_sel, // rot_pkg op code
	input wire logic [7:0] mem_rdata, // operand byte from data memory
	input wire logic cy_in, // current carry flag
	output logic [7:0] acc_out, // accumulator result, registered
	output logic acc_we, // pulse: acc_out valid this cycle
	output logic [7:0] mem_wdata, // memory write data, registered
	output logic mem_we, // pulse: write mem_wdata back
	output logic cy_out, // new carry, registered
	output logic cy_we // pulse: carry flag update
);
	// all state in one struct
	typedef struct packed {
		logic [7:0] acc;
		logic acc_we;
		logic [7:0] mem;
		logic mem_we;
		logic cy;
		logic cy_we;
	} state_t;

	state_t st;
	state_t next_st;
	logic dir_right; // rotator direction
	logic fill; // bit entering the rotated byte
	logic [7:0] rot_val; // rotated byte
	logic out_bit; // bit leaving the rotated byte
	logic via_cy; // nine-bit form selected

	// decode direction and form
	always_comb begin
		dir_right = (op_sel == rot_pkg::op_rotate_right_in_place) ||
			(op_sel == rot_pkg::op_rotate_right_copy) ||
			(op_sel == rot_pkg::op_rotate_right_via_cy);
		via_cy = (op_sel == rot_pkg::op_rotate_left_via_cy) ||
			(op_sel == rot_pkg::op_rotate_left_via_cy_copy) ||
			(op_sel == rot_pkg::op_rotate_right_via_cy);
		// old carry sampled here, before any update lands
		fill = via_cy ? cy_in : (dir_right ?
			mem_rdata[rot_pkg::lsb_pos] : mem_rdata[rot_pkg::msb_pos]);
	end

	// one shared rotator; the fill bit picks plain or nine-bit form
	rot_shifter u_shift (
		.din(mem_rdata),
		.dir_right(dir_right),
		.fill(fill),
		.dout(rot_val),
		.out_bit(out_bit)
	);

	// next state: strobes default low, data held
	always_comb begin
		next_st = st;
		next_st.acc_we = 1'b0;
		next_st.mem_we = 1'b0;
		next_st.cy_we = 1'b0;
		if (op_valid) begin
			case (op_sel)
				rot_pkg::op_rotate_left_copy: begin
					// acc only, memory and flags untouched
					next_st.acc = rot_val;
					next_st.acc_we = 1'b1;
				end
				rot_pkg::op_rotate_left_via_cy: begin
					// back to memory, carry gets old bit 7
					next_st.mem = rot_val;
					next_st.mem_we = 1'b1;
					next_st.cy = out_bit;
					next_st.cy_we = 1'b1;
				end
				rot_pkg::op_rotate_left_via_cy_copy: begin
					// acc result, carry gets old bit 7
					next_st.acc = rot_val;
					next_st.acc_we = 1'b1;
					next_st.cy = out_bit;
					next_st.cy_we = 1'b1;
				end
				rot_pkg::op_rotate_right_in_place: begin
					// memory only, flags untouched
					next_st.mem = rot_val;
					next_st.mem_we = 1'b1;
				end
				rot_pkg::op_rotate_right_copy: begin
					// acc only
					next_st.acc = rot_val;
					next_st.acc_we = 1'b1;
				end
				rot_pkg::op_rotate_right_via_cy: begin
					// back to memory, carry gets old bit 0
					next_st.mem = rot_val;
					next_st.mem_we = 1'b1;
					next_st.cy = out_bit;
					next_st.cy_we = 1'b1;
				end
				default: begin
					// unknown codes do nothing, safer than guessing
					// strobes stay low from the defaults above
				end
			endcase
		end
	end

	// register the state; ce low freezes everything
	always_ff @(posedge clk) begin
		if (rst) begin
			// reset wins over ce, so a frozen unit still clears
			st <= '{acc: rot_pkg::acc_rst, acc_we: 1'b0,
				mem: rot_pkg::mem_rst, mem_we: 1'b0,
				cy: rot_pkg::cy_rst, cy_we: 1'b0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	// outputs come straight from the flops, no glue after them
	assign acc_out = st.acc;
	assign acc_we = st.acc_we;
	assign mem_wdata = st.mem;
	assign mem_we = st.mem_we;
	assign cy_out = st.cy;
	assign cy_we = st.cy_we;


	// each op shows its result one edge later, on its own strobes
	chk_left_copy: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_left_copy |=>
		acc_we && !mem_we && !cy_we &&
		acc_out == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
		else $error("left copy result wrong");
	chk_left_carry: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_left_via_cy |=>
		mem_we && cy_we && !acc_we && cy_out == $past(mem_rdata[7]) &&
		mem_wdata == {$past(mem_rdata[6:0]), $past(cy_in)})
		else $error("left via carry wrong");
	chk_left_carry_copy: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_left_via_cy_copy
		|=> acc_we && cy_we && !mem_we && cy_out == $past(mem_rdata[7])
		&& acc_out == {$past(mem_rdata[6:0]), $past(cy_in)})
		else $error("left via carry copy wrong");
	chk_right_place: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_right_in_place |=>
		mem_we && !acc_we && !cy_we &&
		mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
		else $error("right in place wrong");
	chk_right_copy: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_right_copy |=>
		acc_we && !mem_we && !cy_we &&
		acc_out == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
		else $error("right copy wrong");
	chk_right_carry: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_right_via_cy |=>
		mem_we && cy_we && !acc_we && cy_out == $past(mem_rdata[0]) &&
		mem_wdata == {$past(cy_in), $past(mem_rdata[7:1])})
		else $error("right via carry wrong");
	// a carry taken after its update would make the rotated-in bit equal the new carry
	chk_carry_old_value: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && op_sel == rot_pkg::op_rotate_right_via_cy &&
		cy_in != mem_rdata[0] |=> mem_wdata[7] != cy_out)
		else $error("carry not taken before update");
	// destinations that an op does not name must keep their value
	chk_flag_untouched: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && (op_sel == rot_pkg::op_rotate_left_copy ||
		op_sel == rot_pkg::op_rotate_right_in_place ||
		op_sel == rot_pkg::op_rotate_right_copy) |=> $stable(cy_out))
		else $error("carry moved on a flag-free op");
	chk_mem_untouched: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && (op_sel == rot_pkg::op_rotate_left_copy ||
		op_sel == rot_pkg::op_rotate_left_via_cy_copy ||
		op_sel == rot_pkg::op_rotate_right_copy) |=> $stable(mem_wdata))
		else $error("memory data moved on an acc op");
	chk_acc_untouched: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && (op_sel == rot_pkg::op_rotate_left_via_cy ||
		op_sel == rot_pkg::op_rotate_right_in_place ||
		op_sel == rot_pkg::op_rotate_right_via_cy) |=> $stable(acc_out))
		else $error("acc moved on a memory op");
	// no instruction, or a code outside the table, leaves no strobe
	chk_idle_no_strobe: assert property (
		@(posedge clk) disable iff (rst)
		ce && !op_valid |=> !acc_we && !mem_we && !cy_we)
		else $error("strobe without instruction");
	chk_bad_code_quiet: assert property (
		@(posedge clk) disable iff (rst)
		ce && op_valid && (op_sel == rot_pkg::op_none ||
		op_sel > rot_pkg::op_rotate_right_via_cy) |=>
		!acc_we && !mem_we && !cy_we)
		else $error("strobe on an unused code");
	// ce low freezes results and strobes alike
	chk_freeze_hold: assert property (
		@(posedge clk) disable iff (rst)
		!ce |=> $stable(acc_out) && $stable(cy_out) && $stable(mem_we))
		else $error("state moved while frozen");
	chk_freeze_data: assert property (
		@(posedge clk) disable iff (rst)
		!ce |=> $stable(mem_wdata) && $stable(acc_we) && $stable(cy_we))
		else $error("data or strobe moved while frozen");
endmodule

// >>> bench/rot_partner.sv
// data memory byte and carry flag seen by the rotate unit
module rot_partner (
	input wire logic clk,
	input wire logic ld, // bench preload strobe
	input wire logic [7:0] ld_mem,
	input wire logic ld_cy,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic cy_out,
	input wire logic cy_we,
	output logic [7:0] mem_rdata,
	output logic cy_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// write-backs land one edge after the strobe, like real memory
	always @(posedge clk) begin
		if (ld) begin
			mem_rdata <= ld_mem;
			cy_in <= ld_cy;
		end else begin
			if (mem_we)
				mem_rdata <= mem_wdata;
			if (cy_we)
				cy_in <= cy_out;
		end
	end
endmodule

// >>> bench/test_byte_rotate_unit.sv
module test_byte_rotate_unit;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, ce = 1, op_valid = 0, ld = 0, ld_cy = 0;
	logic [2:0] op_sel = 3'h0;
	logic [7:0] ld_mem = 8'h00, mem_rdata, acc_out, mem_wdata;
	logic cy_in, acc_we, mem_we, cy_out, cy_we;
	int errors = 0, n_checks = 0;
	// row: op, byte, carry in, result, carry after
	logic [20:0] rows [8] = '{{3'h1, 8'h81, 1'h1, 8'h03, 1'h1},
		{3'h2, 8'h81, 1'h0, 8'h02, 1'h1}, {3'h3, 8'h40, 1'h1, 8'h81, 1'h0},
		{3'h4, 8'h01, 1'h0, 8'h80, 1'h0}, {3'h5, 8'h02, 1'h1, 8'h01, 1'h1},
		{3'h6, 8'h02, 1'h1, 8'h81, 1'h0}, {3'h7, 8'h55, 1'h1, 8'h55, 1'h1},
		{3'h0, 8'haa, 1'h0, 8'haa, 1'h0}};
	always #12.5 clk = ~clk;
	byte_rotate_unit i_byte_rotate_unit (.clk(clk), .rst(rst), .ce(ce),
		.op_valid(op_valid), .op_sel(op_sel), .mem_rdata(mem_rdata),
		.cy_in(cy_in), .acc_out(acc_out), .acc_we(acc_we),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .cy_out(cy_out),
		.cy_we(cy_we));
	rot_partner i_rot_partner (.clk(clk), .ld(ld), .ld_mem(ld_mem),
		.ld_cy(ld_cy), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.cy_out(cy_out), .cy_we(cy_we), .mem_rdata(mem_rdata),
		.cy_in(cy_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// preload, issue one op, check strobes then the write-back
	task automatic go(input logic [20:0] r, input logic en);
		logic [2:0] s;
		logic a, m, c;
		s = r[20:18];
		a = en && s inside {3'h1, 3'h3, 3'h5};
		m = en && s inside {3'h2, 3'h4, 3'h6};
		c = en && s inside {3'h2, 3'h3, 3'h6};
		@(posedge clk);
		ld <= 1;
		ld_mem <= r[17:10];
		ld_cy <= r[9];
		@(posedge clk);
		ld <= 0;
		op_valid <= 1;
		op_sel <= s;
		ce <= en;
		@(posedge clk);
		op_valid <= 0;
		ce <= 1;
		#1 chk({5'h0, acc_we, mem_we, cy_we}, {5'h0, a, m, c});
		if (a)
			chk(acc_out, r[8:1]);
		@(posedge clk);
		#1 chk(mem_rdata, m ? r[8:1] : r[17:10]);
		chk({7'h0, cy_in}, {7'h0, en ? r[0] : r[9]});
	endtask
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		#1 chk(acc_out | mem_wdata, 8'h00);
		chk({5'h0, acc_we, mem_we, cy_we}, 8'h00);
		foreach (rows[i])
			go(rows[i], 1'b1);
		// clock enable low must swallow a valid op
		go(rows[1], 1'b0);
		// mid-run reset; first op right on the release edge
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		op_valid <= 1;
		op_sel <= rot_pkg::op_rotate_right_copy;
		#1 chk(acc_out | mem_wdata | {7'h0, cy_out}, 8'h00);
		// back to back: a second op on the very next edge
		@(posedge clk);
		op_sel <= rot_pkg::op_rotate_left_copy;
		#1 chk(acc_out, 8'hc0);
		// ce low just after an op: its strobe must stand
		@(posedge clk);
		op_valid <= 0;
		ce <= 0;
		#1 chk(acc_out, 8'h03);
		@(posedge clk);
		ce <= 1;
		#1 chk({5'h0, acc_we, mem_we, cy_we}, 8'h04);
		@(posedge clk);
		#1 chk({5'h0, acc_we, mem_we, cy_we}, 8'h00);
		summarize();
	end
endmodule
